/* core/tlbtm_core.sv */
// Module: TLB tag match, insertion and invalidation filter with APB control
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module tlbtm_core
    import tlbtm_pkg::*;
#(
    parameter int N_ENT     = 8,
    parameter bit WIDE_ASID = 1'b1,
    parameter bit WIDE_VMID = 1'b1,
    parameter bit HYP_SUP   = 1'b1,
    parameter bit SEC_HYP   = 1'b1,
    parameter bit BCAST_SUP = 1'b1
) (
    input  wire logic         i_clk,       // 100 MHz clock
    input  wire logic         i_rst_b,     // Async reset, low
    input  wire logic         i_ce,        // Clock enable
    input  wire logic         i_psel,      // APB select
    input  wire logic         i_penable,   // APB enable
    input  wire logic         i_pwrite,    // APB direction
    input  wire logic [7:0]   i_paddr,     // APB byte address
    input  wire logic [31:0]  i_pwdata,    // APB write data
    input  wire logic [3:0]   i_pstrb,     // APB byte strobes
    output logic [31:0]       o_prdata,    // APB read data
    output logic              o_pready,    // APB ready
    output logic              o_pslverr,   // APB error
    input  wire logic         i_lkp_valid, // Lookup request
    input  wire tlbtm_lkp_t   i_lkp,       // Lookup tags
    output logic              o_lkp_vld,   // Lookup answer
    output logic              o_lkp_hit,   // Lookup hit
    output logic [PA_W-1:0]   o_lkp_pa,    // Output page
    input  wire logic         i_ins_valid, // Insert request
    input  wire tlbtm_ins_t   i_ins,       // Insert tags
    output logic              o_ins_err,   // Insert refused
    input  wire logic         i_inv_valid, // Invalidation request
    input  wire tlbtm_inv_t   i_inv,       // Invalidation scope
    output logic              o_inv_ack,   // Invalidation done
    output logic [5:0]        o_inv_count  // Entries removed
);

    localparam int IW = (N_ENT > 1) ? $clog2(N_ENT) : 1;

    // ****************************************************
    // Reset release
    // ****************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************************
    // Register bus
    // ****************************************************
    logic [3:0]        ctrl_reg;
    logic [31:0]       rd_reg;
    logic              err_reg;
    logic [N_ENT-1:0]  vld_vec;
    logic [4:0]        id_bits;

    assign id_bits = {BCAST_SUP, SEC_HYP, HYP_SUP,
                      WIDE_VMID, WIDE_ASID};
    // Data is fetched in the setup phase, so the access phase waits only while i_ce is low
    assign o_pready  = i_ce;
    assign o_prdata  = rd_reg;
    assign o_pslverr = err_reg && i_psel && i_penable;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
        end else if (i_ce && i_psel && i_penable && i_pwrite &&
                     i_paddr == ADDR_CTRL && i_pstrb[0]) begin
            ctrl_reg <= i_pwdata[3:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_reg  <= 32'h0;
            err_reg <= 1'b0;
        end else if (i_ce && i_psel && !i_penable) begin
            err_reg <= 1'b0;
            case (i_paddr)
                ADDR_CTRL: rd_reg <= {28'h0, ctrl_reg};
                ADDR_ID:   rd_reg <= {27'h0, id_bits};
                ADDR_STAT: rd_reg <= 32'(vld_vec);
                default: begin
                    rd_reg  <= 32'h0;
                    err_reg <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************
    // Matching functions
    // ****************************************************
    function automatic logic host_ok(tlbtm_regime_t r, logic sec);
        logic allow;
        allow = sec ? (SEC_HYP && ctrl_reg[CTRL_HOST_S])
                    : (HYP_SUP && ctrl_reg[CTRL_HOST_NS]);
        return r != RG_HOST || allow;
    endfunction

    function automatic logic uses_vmid(tlbtm_regime_t r);
        return r == RG_GUEST || (r == RG_SECURE && SEC_HYP);
    endfunction

    function automatic logic lkp_hit(tlbtm_entry_t e, tlbtm_lkp_t q);
        logic rg_ok;
        logic asid_ok;
        logic set_ok;
        logic vm_ok;
        rg_ok   = e.valid && e.regime == q.regime &&
                  e.secure == q.secure;
        asid_ok = !has_asid(e.regime) || e.glob ||
                  id_eq(e.asid, q.asid, WIDE_ASID);
        set_ok  = !e.glob || e.addr_set == q.addr_set;
        vm_ok   = !uses_vmid(e.regime) ||
                  id_eq(e.vmid, q.vmid, WIDE_VMID);
        return rg_ok && asid_ok && set_ok && vm_ok &&
               e.va == q.va;
    endfunction

    function automatic tlbtm_entry_t mk_entry(tlbtm_ins_t r);
        tlbtm_entry_t e;
        e.valid  = 1'b1;
        e.regime = r.regime;
        e.secure = r.secure;
        e.addr_set = r.addr_set;
        e.va     = r.va;
        e.pa     = r.pa;
        // Only ASID regimes know global; a non-secure fetch forces local
        e.glob   = has_asid(r.regime) && !r.not_global &&
                   !(r.secure && r.desc_ns);
        // Width follows the capability alone, never the format bits
        e.asid   = (e.glob || !has_asid(r.regime)) ? '0 :
                   (WIDE_ASID ? r.asid
                              : {8'h0, r.asid[7:0]});
        e.vmid   = WIDE_VMID ? r.vmid : {8'h0, r.vmid[7:0]};
        if (r.regime == RG_SECURE && (!SEC_HYP || !r.s2_en)) begin
            e.vmid = '0;
        end
        return e;
    endfunction

    function automatic logic inv_hit(tlbtm_entry_t e, tlbtm_inv_t v);
        tlbtm_regime_t tgt;
        logic          rg_ok;
        logic          id_ok;
        logic          va_ok;
        logic          vm_ok;
        logic          op_ok;
        logic          set_ex;
        case (v.level)
            LV_GUEST: tgt = v.secure ? RG_SECURE : RG_GUEST;
            LV_HYP:   tgt = v.host_form ? RG_HOST : RG_HYP;
            default:  tgt = RG_MON;
        endcase
        // Cross-regime operations stay in their own regime
        rg_ok = e.valid && e.regime == tgt &&
                e.secure == v.secure;
        id_ok = id_eq(e.asid, v.asid, WIDE_ASID);
        va_ok = e.va == v.va;
        case (v.op)
            OP_ALL:  op_ok = 1'b1;
            OP_ASID: op_ok = has_asid(e.regime) && !e.glob &&
                             id_ok;
            OP_VA:   op_ok = va_ok && (!has_asid(e.regime) ||
                             e.glob || id_ok);
            default: op_ok = va_ok && e.regime != RG_MON;
        endcase
        if (e.regime == RG_GUEST) begin
            vm_ok = id_eq(e.vmid, v.vmid, WIDE_VMID);
        end else if (e.regime != RG_SECURE) begin
            vm_ok = 1'b1;
        end else if (v.from_cmd) begin
            vm_ok = !SEC_HYP || id_eq(e.vmid, v.vmid, WIDE_VMID);
        end else if (v.pe_sh_en) begin
            vm_ok = SEC_HYP &&
                    id_eq(e.vmid, v.vmid, WIDE_VMID);
        end else begin
            vm_ok = !SEC_HYP ||
                    id_eq(e.vmid, {TAG_W{1'b0}}, WIDE_VMID);
        end
        // Non-shared spaces skip ASID-matching broadcasts only
        set_ex  = !v.from_cmd && e.addr_set &&
                  (v.op == OP_ASID || v.op == OP_VA);
        return rg_ok && op_ok && vm_ok && !set_ex;
    endfunction

    // ****************************************************
    // Entry store and match vectors
    // ****************************************************
    tlbtm_entry_t      ent [N_ENT];
    logic [N_ENT-1:0]  lk_match;
    logic [N_ENT-1:0]  kill;
    logic [N_ENT-1:0]  glob_vec;
    logic [N_ENT-1:0]  rg_vec;
    logic              mon_live;
    logic [PA_W-1:0]   hit_pa;
    logic [IW-1:0]     vic;
    logic [IW-1:0]     rr_reg;
    logic              has_free;
    logic [5:0]        kill_cnt;
    logic              bc_drop;
    logic              inv_fire;
    logic              ins_ok;
    logic              ins_fire;

    // Opted-out or unsupported broadcasts are answered but do nothing
    assign bc_drop  = !i_inv.from_cmd && (!BCAST_SUP ||
                      (i_inv.secure ? ctrl_reg[CTRL_OPT_S]
                                    : ctrl_reg[CTRL_OPT_NS]));
    assign inv_fire = i_inv_valid && i_ce && !bc_drop;
    // An assign would miss the function's hidden read of ctrl_reg
    always_comb begin
        ins_ok = host_ok(i_ins.regime, i_ins.secure);
    end
    assign ins_fire = i_ins_valid && i_ce && ins_ok;

    always_comb begin
        hit_pa   = '0;
        vic      = rr_reg;
        has_free = 1'b0;
        kill_cnt = 6'h0;
        mon_live = 1'b0;
        for (int k = N_ENT - 1; k >= 0; k--) begin
            lk_match[k] = lkp_hit(ent[k], i_lkp) &&
                          host_ok(i_lkp.regime, i_lkp.secure);
            kill[k]     = inv_fire && inv_hit(ent[k], i_inv);
            glob_vec[k] = ent[k].valid && ent[k].glob;
            rg_vec[k]   = ent[k].valid &&
                          ent[k].regime == i_lkp.regime &&
                          ent[k].secure == i_lkp.secure;
            vld_vec[k]  = ent[k].valid;
            if (lk_match[k]) begin
                hit_pa = ent[k].pa;
            end
            if (!ent[k].valid) begin
                vic      = IW'(k);
                has_free = 1'b1;
            end
            if (ent[k].valid && ent[k].regime == RG_MON) begin
                mon_live = 1'b1;
            end
            kill_cnt = kill_cnt + 6'(kill[k]);
        end
    end

    // Insert lands after the kill, so a new entry survives its own cycle
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < N_ENT; k++) begin
                ent[k] <= '0;
            end
        end else if (i_ce) begin
            for (int k = 0; k < N_ENT; k++) begin
                if (kill[k]) begin
                    ent[k].valid <= 1'b0;
                end
            end
            if (ins_fire) begin
                ent[vic] <= mk_entry(i_ins);
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rr_reg <= '0;
        end else if (ins_fire && !has_free) begin
            rr_reg <= (rr_reg == IW'(N_ENT - 1)) ? '0 : rr_reg + 1'b1;
        end
    end

    // ****************************************************
    // Answers
    // ****************************************************
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_lkp_vld <= 1'b0;
            o_lkp_hit <= 1'b0;
            o_lkp_pa  <= '0;
        end else if (i_ce) begin
            o_lkp_vld <= i_lkp_valid;
            o_lkp_hit <= i_lkp_valid && |lk_match;
            o_lkp_pa  <= hit_pa;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ins_err   <= 1'b0;
            o_inv_ack   <= 1'b0;
            o_inv_count <= 6'h0;
        end else if (i_ce) begin
            o_ins_err   <= i_ins_valid && !ins_ok;
            o_inv_ack   <= i_inv_valid;
            o_inv_count <= kill_cnt;
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    sequence s_ins_sec_ns;
        i_ins_valid && i_ce && ins_ok && i_ins.secure && i_ins.desc_ns;
    endsequence

    sequence s_ins_no_asid;
        i_ins_valid && i_ce && ins_ok &&
        (i_ins.regime == RG_HYP || i_ins.regime == RG_MON);
    endsequence

    sequence s_bc_opted;
        i_inv_valid && i_ce && bc_drop;
    endsequence

    sequence s_mon_all;
        i_inv_valid && i_ce && !bc_drop &&
        i_inv.level == LV_MON && i_inv.secure && i_inv.op == OP_ALL &&
        !(i_ins_valid && i_ins.regime == RG_MON);
    endsequence

    a_ns_desc_local: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        s_ins_sec_ns |=> !ent[$past(vic)].glob)
        else $error("secure entry from ns descriptor marked global");

    a_no_asid_tag: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        s_ins_no_asid |=> !ent[$past(vic)].glob &&
                          ent[$past(vic)].asid == '0)
        else $error("asid-less regime entry got asid or global");

    a_lkp_regime: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_lkp_valid && i_ce && rg_vec == '0) |=> !o_lkp_hit)
        else $error("lookup hit an entry of another regime");

    a_vmid_zero: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_ins_valid && i_ce && ins_ok && i_ins.regime == RG_SECURE &&
         !i_ins.s2_en) |=> ent[$past(vic)].vmid == '0)
        else $error("secure entry without stage 2 kept nonzero vmid");

    a_host_gate: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_ins_valid && i_ce && i_ins.regime == RG_HOST &&
         !(i_ins.secure ? SEC_HYP && ctrl_reg[CTRL_HOST_S]
                        : HYP_SUP && ctrl_reg[CTRL_HOST_NS]))
        |=> o_ins_err)
        else $error("host regime insert not refused");

    a_optout_drop: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        s_bc_opted |=> o_inv_ack && o_inv_count == 6'h0)
        else $error("opted-out broadcast removed entries");

    a_mon_all: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        s_mon_all |=> !mon_live)
        else $error("monitor invalidate-all left monitor entries");

    a_asid_keeps: assert property (
        @(posedge i_clk) disable iff (!rst_n)
        (i_inv_valid && i_ce && i_inv.op == OP_ASID)
        |-> (kill & glob_vec) == '0)
        else $error("asid-scoped invalidation removed global entry");

endmodule

/* core/tlbtm_pkg.sv */
// Package: types and constants of the TLB tag match and invalidation filter
// Function
// - Secure-stream translation from non-secure descriptor memory is non-global.
// - Hypervisor and monitor regimes use no ASID; global flag ignored.
// - Global entries store no ASID and hit any lookup ASID.
// - No entry hits a lookup from a different stream regime.
// - Global entries hit only when address-set flags are equal.
// - ASID-scoped invalidations leave global entries; other scopes remove them.
// - Secure entries tagged secure; secure guest broadcasts and commands remove them.
// - Monitor entries carry no ASID; monitor VA and all remove them.
// - Secure guest broadcast without enabled secure hypervisor uses VMID 0 or none.
// - With enabled secure hypervisor, such broadcasts match VMID or are ignored.
// - With secure hypervisor, secure entries without stage 2 get VMID 0.
// - Monitor entries may survive secure guest or narrow secure invalidations.
// - Secure entries may survive monitor-level invalidations.
// - ASID and VMID widths 8 or 16, shown by read-only bits.
// - Wide identifiers compare all 16 bits for equality.
// - Narrow identifiers compare low 8 bits; upper byte may be ignored.
// - Wide ASIDs and VMIDs apply whatever the descriptor format.
// - Plain hypervisor regime entries carry no ASID tag.
// - Host hypervisor regime entries carry an ASID when non-global.
// - Host regime allowed only with support and host-mode control set.
// - Host broadcasts: all, by VA and ASID, by VA any ASID, by ASID.
// - Commands remove matching entries whatever their address-set flag.
// - Address-set entries may survive ASID-matching broadcasts, never all.
// - Broadcasts of a security state are dropped when its opt-out is set.
package tlbtm_pkg;

    localparam int TAG_W = 16;
    localparam int VA_W  = 36;
    localparam int PA_W  = 28;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ID   = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam int CTRL_OPT_NS  = 0;
    localparam int CTRL_OPT_S   = 1;
    localparam int CTRL_HOST_NS = 2;
    localparam int CTRL_HOST_S  = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    typedef enum logic [2:0] {
        RG_GUEST  = 3'h0,
        RG_SECURE = 3'h1,
        RG_HOST   = 3'h3,
        RG_HYP    = 3'h2,
        RG_MON    = 3'h6
    } tlbtm_regime_t;

    typedef enum logic [1:0] {
        LV_GUEST = 2'h0,
        LV_HYP   = 2'h1,
        LV_MON   = 2'h3
    } tlbtm_level_t;

    typedef enum logic [1:0] {
        OP_ALL  = 2'h0,
        OP_ASID = 2'h1,
        OP_VA   = 2'h3,
        OP_VAA  = 2'h2
    } tlbtm_op_t;

    typedef struct packed {
        tlbtm_regime_t     regime;
        logic              secure;
        logic              addr_set;
        logic [TAG_W-1:0]  asid;
        logic [TAG_W-1:0]  vmid;
        logic [VA_W-1:0]   va;
    } tlbtm_lkp_t;

    typedef struct packed {
        tlbtm_regime_t     regime;
        logic              secure;
        logic              addr_set;
        logic              not_global;
        logic              desc_ns;
        logic              s2_en;
        logic [TAG_W-1:0]  asid;
        logic [TAG_W-1:0]  vmid;
        logic [VA_W-1:0]   va;
        logic [PA_W-1:0]   pa;
    } tlbtm_ins_t;

    typedef struct packed {
        logic              from_cmd;
        tlbtm_level_t      level;
        logic              secure;
        logic              host_form;
        tlbtm_op_t         op;
        logic              pe_sh_en;
        logic [TAG_W-1:0]  asid;
        logic [TAG_W-1:0]  vmid;
        logic [VA_W-1:0]   va;
    } tlbtm_inv_t;

    typedef struct packed {
        logic              valid;
        tlbtm_regime_t     regime;
        logic              secure;
        logic              glob;
        logic              addr_set;
        logic [TAG_W-1:0]  asid;
        logic [TAG_W-1:0]  vmid;
        logic [VA_W-1:0]   va;
        logic [PA_W-1:0]   pa;
    } tlbtm_entry_t;

    function automatic logic has_asid(tlbtm_regime_t r);
        return r == RG_GUEST || r == RG_SECURE || r == RG_HOST;
    endfunction

    function automatic logic id_eq(logic [TAG_W-1:0] t,
                                   logic [TAG_W-1:0] v,
                                   logic             wide);
        // Narrow tags accept a non-zero upper byte: cheaper, and allowed
        return wide ? (t == v) : (t[7:0] == v[7:0]);
    endfunction

endpackage

/* testbench/tb_top.sv */
// Testbench: APB, lookup, insert and invalidation checks of the TLB filter
`timescale 1ns/1ps
module tb_top
    import tlbtm_pkg::*;
;
    logic              i_clk, i_rst_b, psel, penable, pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, er, ok;
    logic              lkp_v, lkp_vld, lkp_hit, ins_v, ins_err;
    logic              inv_v, inv_ack, ce;
    logic [PA_W-1:0]   lkp_pa;
    logic [5:0]        inv_cnt, cnt;
    tlbtm_lkp_t        lkp;
    tlbtm_ins_t        ins_d;
    tlbtm_inv_t        inv_d;
    int                n_errors = 0;
    int                cmp_count = 0;
    int                cyc = 0;

    tlbtm_core dut_u (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_lkp_valid(lkp_v), .i_lkp(lkp), .o_lkp_vld(lkp_vld),
        .o_lkp_hit(lkp_hit), .o_lkp_pa(lkp_pa), .i_ins_valid(ins_v),
        .i_ins(ins_d), .o_ins_err(ins_err), .i_inv_valid(inv_v),
        .i_inv(inv_d), .o_inv_ack(inv_ack), .o_inv_count(inv_cnt));

    tlbtm_pe_model pe_u (.i_clk(i_clk), .i_inv_ack(inv_ack),
        .i_inv_count(inv_cnt), .o_inv_valid(inv_v), .o_inv(inv_d));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // ****************************************************
    // Checks and bus tasks
    // ****************************************************
    task automatic final_report;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t word %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_b(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t flag %b exp %b", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic look(input tlbtm_lkp_t l, input logic h,
                        input logic [PA_W-1:0] p);
        @(posedge i_clk);
        lkp_v <= 1'b1;
        lkp   <= l;
        @(posedge i_clk);
        lkp_v <= 1'b0;
        lkp   <= ~l;
        #1;
        chk_b(lkp_vld, 1'b1);
        chk_b(lkp_hit, h);
        if (h) chk({4'h0, lkp_pa}, {4'h0, p});
    endtask

    task automatic ins(input tlbtm_ins_t d, input logic e);
        @(posedge i_clk);
        ins_v <= 1'b1;
        ins_d <= d;
        @(posedge i_clk);
        ins_v <= 1'b0;
        ins_d <= ~d;
        #1;
        chk_b(ins_err, e);
    endtask

    task automatic bc(input tlbtm_inv_t v, input bit nar,
                      input logic [5:0] n);
        pe_u.send(v, nar, cnt, ok);
        chk_b(ok, 1'b1);
        chk({26'h0, cnt}, {26'h0, n});
    endtask

    function automatic tlbtm_lkp_t mk_l(tlbtm_regime_t g, logic s,
        logic a, logic [15:0] id, logic [VA_W-1:0] v);
        return '{g, s, a, id, 16'h0000, v};
    endfunction

    function automatic tlbtm_ins_t mk_i(tlbtm_regime_t g, logic s,
        logic ng, logic dn, logic [15:0] id, logic [VA_W-1:0] v);
        return '{g, s, 1'b0, ng, dn, 1'b0, id, 16'h0000, v, v[27:0]};
    endfunction

    function automatic tlbtm_inv_t mk_v(logic c, tlbtm_level_t lv,
        logic s, logic h, tlbtm_op_t op, logic [15:0] id);
        return '{c, lv, s, h, op, 1'b0, id, 16'h0000, 36'h0};
    endfunction

    // Hang guard, well above the length of the sequence
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            final_report();
        end
    end

    // ****************************************************
    // Sequence
    // ****************************************************
    initial begin
        {psel, penable, pwrite, lkp_v, ins_v} = '0;
        ce = 1'b1;
        {paddr, pwdata, lkp, ins_d} = '0;
        i_rst_b = 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b1, ADDR_ID, 32'h0);
        apb(1'b0, ADDR_ID, 32'h0);
        chk(rd, 32'h0000_001f);
        apb(1'b0, 8'h0c, 32'h0);
        chk_b(er, 1'b1);
        ins(mk_i(RG_GUEST, 1'b0, 1'b0, 1'b0, 16'h0005, 36'h100), 1'b0);
        look(mk_l(RG_GUEST, 1'b0, 1'b0, 16'h0009, 36'h100), 1'b1, 28'h100);
        look(mk_l(RG_GUEST, 1'b0, 1'b1, 16'h0005, 36'h100), 1'b0, 28'h0);
        look(mk_l(RG_HYP, 1'b0, 1'b0, 16'h0005, 36'h100), 1'b0, 28'h0);
        ins(mk_i(RG_GUEST, 1'b0, 1'b1, 1'b0, 16'h0105, 36'h200), 1'b0);
        look(mk_l(RG_GUEST, 1'b0, 1'b0, 16'h0005, 36'h200), 1'b0, 28'h0);
        look(mk_l(RG_GUEST, 1'b0, 1'b0, 16'h0105, 36'h200), 1'b1, 28'h200);
        ins(mk_i(RG_SECURE, 1'b1, 1'b0, 1'b1, 16'h0007, 36'h300), 1'b0);
        look(mk_l(RG_SECURE, 1'b1, 1'b0, 16'h0008, 36'h300), 1'b0, 28'h0);
        look(mk_l(RG_SECURE, 1'b1, 1'b0, 16'h0007, 36'h300), 1'b1, 28'h300);
        ins(mk_i(RG_MON, 1'b1, 1'b1, 1'b0, 16'h0003, 36'h400), 1'b0);
        look(mk_l(RG_MON, 1'b1, 1'b0, 16'h0009, 36'h400), 1'b1, 28'h400);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h0000_000f);
        bc(mk_v(1'b0, LV_GUEST, 1'b0, 1'b0, OP_ASID, 16'h0005), 1'b1, 6'd0);
        bc(mk_v(1'b0, LV_GUEST, 1'b0, 1'b0, OP_ASID, 16'h0105), 1'b0, 6'd1);
        bc(mk_v(1'b0, LV_MON, 1'b1, 1'b0, OP_ALL, 16'h0000), 1'b0, 6'd1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        bc(mk_v(1'b0, LV_GUEST, 1'b1, 1'b0, OP_ALL, 16'h0000), 1'b0, 6'd0);
        bc(mk_v(1'b1, LV_GUEST, 1'b1, 1'b0, OP_ALL, 16'h0000), 1'b0, 6'd1);
        bc(mk_v(1'b0, LV_GUEST, 1'b0, 1'b0, OP_ALL, 16'h0000), 1'b0, 6'd1);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h0000_0000);
        ins(mk_i(RG_HOST, 1'b0, 1'b1, 1'b0, 16'h0022, 36'h500), 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0006);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_0006);
        ins(mk_i(RG_HOST, 1'b0, 1'b1, 1'b0, 16'h0022, 36'h500), 1'b0);
        look(mk_l(RG_HOST, 1'b0, 1'b0, 16'h0023, 36'h500), 1'b0, 28'h0);
        look(mk_l(RG_HOST, 1'b0, 1'b0, 16'h0022, 36'h500), 1'b1, 28'h500);
        bc(mk_v(1'b0, LV_HYP, 1'b0, 1'b1, OP_ASID, 16'h0022), 1'b0, 6'd1);
        ins(mk_i(RG_GUEST, 1'b0, 1'b1, 1'b0, 16'h0033, 36'h0), 1'b0);
        bc(mk_v(1'b0, LV_GUEST, 1'b0, 1'b0, OP_VA, 16'h0034),
           1'b0, 6'd0);
        bc(mk_v(1'b0, LV_GUEST, 1'b0, 1'b0, OP_VAA, 16'h0034),
           1'b0, 6'd1);
        // A frozen clock enable must swallow the insert entirely
        @(posedge i_clk) ce <= 1'b0;
        ins(mk_i(RG_GUEST, 1'b0, 1'b1, 1'b0, 16'h0044, 36'h0), 1'b0);
        @(posedge i_clk) ce <= 1'b1;
        apb(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h0000_0000);
        final_report();
    end
endmodule

/* testbench/tlbtm_pe_model.sv */
// Partner model: processing element issuing broadcast invalidations
`timescale 1ns/1ps
module tlbtm_pe_model
    import tlbtm_pkg::*;
(
    input  wire logic        i_clk,       // Clock
    input  wire logic        i_inv_ack,   // Invalidation done
    input  wire logic [5:0]  i_inv_count, // Entries removed
    output logic             o_inv_valid, // Invalidation request
    output tlbtm_inv_t       o_inv        // Invalidation scope
);
    // ****************************************************
    // Request driver
    // ****************************************************
    initial begin
        o_inv_valid = 1'b0;
        o_inv       = '0;
    end

    // A narrow originator only has a low byte; the fabric widens it
    task automatic send(input tlbtm_inv_t r, input bit narrow,
                        output logic [5:0] cnt, output logic ok);
        tlbtm_inv_t m;
        m = r;
        if (narrow) begin
            m.asid = {8'h00, r.asid[7:0]};
            m.vmid = {8'h00, r.vmid[7:0]};
        end
        @(posedge i_clk);
        o_inv_valid <= 1'b1;
        o_inv       <= m;
        @(posedge i_clk);
        o_inv_valid <= 1'b0;
        // Released scope lines must not keep showing the old request
        o_inv       <= ~m;
        #1;
        ok  = i_inv_ack;
        cnt = i_inv_count;
    endtask
endmodule
